// ==== logic/framer_pkg.sv ====
// Shared constants for the downlink telemetry framer
package framer_pkg;
  // ****************************************
  // Clock and line timing
  // ****************************************
  localparam int unsigned clock_hz = 20000000;
  localparam int unsigned baud_bps = 38400;
  localparam int unsigned bit_cycles = clock_hz / baud_bps;
  localparam int unsigned bits_per_char = 10;
  localparam int unsigned data_bits = 8;
  localparam int unsigned gap_us = 3000;
  localparam int unsigned gap_cycles = (gap_us * (clock_hz / 1000000) + 0) ;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int unsigned max_data_bytes = 32;
  localparam logic [15:0] sync_default = 16'heb90;
  localparam logic [7:0] crc_poly_default = 8'h07;
  localparam logic [7:0] crc_init = 8'h00;
  localparam logic [15:0] counter_reset = 16'h0000;
  localparam logic [15:0] checksum_reset = 16'h0000;
endpackage

// ==== logic/byte_link_if.sv ====
// Byte hand-off between the framer and the serial transmitter
`timescale 1ns/1ps
interface byte_link_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ==== logic/serial_tx.sv ====
// Eight-data-bit, one-stop-bit, no-parity serial transmitter
`timescale 1ns/1ps
module serial_tx
  import framer_pkg::*;
#(
  parameter int unsigned bit_len = bit_cycles
) (
  input wire logic clock,
  input wire logic rst_b,
  byte_link_if.sink link,
  output logic line_q,
  output logic busy_q
);
  logic [15:0] tick_q;
  logic [3:0] bit_q;
  logic [9:0] shift_q;

  // ****************************************
  // Shift one character out
  // ****************************************
  // Ready only between characters, so a byte is never overwritten mid-flight
  assign link.ready = ~busy_q;

  // Baud divider and shifter share one process: timing and data move together
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 16'h0000;
      bit_q <= 4'h0;
      shift_q <= 10'h3ff;
      line_q <= 1'b1;
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      line_q <= 1'b1;
      if (link.valid) begin
        shift_q <= {1'b1, link.data, 1'b0};
        busy_q <= 1'b1;
        tick_q <= 16'h0000;
        bit_q <= 4'h0;
        line_q <= 1'b0;
      end
    end else if (tick_q == 16'(bit_len - 1)) begin
      tick_q <= 16'h0000;
      if (bit_q == 4'(bits_per_char - 1)) begin
        busy_q <= 1'b0;
        line_q <= 1'b1;
      end else begin
        bit_q <= bit_q + 4'h1;
        line_q <= shift_q[bit_q + 4'h1];
      end
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end
endmodule

// ==== logic/crc8_step.sv ====
// One-byte step of a configurable CRC-8
`timescale 1ns/1ps
module crc8_step (
  input wire logic [7:0] poly,
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);
  logic [7:0] stage [0:8];

  // ****************************************
  // Bitwise MSB-first CRC, unrolled by generate
  // ****************************************
  assign stage[0] = crc_in ^ data_in;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign stage[i + 1] = stage[i][7] ? ({stage[i][6:0], 1'b0} ^ poly) : {stage[i][6:0], 1'b0};
    end
  endgenerate
  assign crc_out = stage[8];
endmodule

// ==== logic/telemetry_downlink_framer.sv ====
// Downlink telemetry frame builder driving one serial transmit pin
`timescale 1ns/1ps
module telemetry_downlink_framer
  import framer_pkg::*;
#(
  parameter logic [15:0] sync_word = sync_default,
  parameter logic [7:0] crc_poly = crc_poly_default,
  parameter int unsigned max_bytes = max_data_bytes,
  parameter int unsigned gap_len = gap_cycles,
  parameter int unsigned bit_len = bit_cycles
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic frame_start,
  input wire logic [7:0] software_mode,
  input wire logic [5:0] data_length,
  input wire logic data_valid,
  input wire logic [7:0] data_byte,
  output logic data_ready_q,
  output logic start_ready_q,
  output logic frame_done_q,
  output logic [15:0] message_counter_q,
  output logic tx_line_q
);
  // ****************************************
  // Frame layout and timing
  // ****************************************
  // sync(2) counter(2) mode(1) data(0..32) checksum(2) crc(1), each byte one character.
  // Characters follow each other with one extra stop cycle between them, so a character
  // takes ten bit times plus one clock.
  // A frame is taken only in idle; start requests during a frame are dropped.
  // Data bytes are taken at the start bit of their character, so the source must hold
  // each byte with data_valid until it has gone; data_ready_q is a late hint only.
  // The gap timer runs from the end of the last stop bit, never from the CRC launch.
  // Limitation: the length is clamped, not rejected, so an oversize request still sends 32 bytes.

  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_sync = 8'h02,
    st_count = 8'h04,
    st_mode = 8'h08,
    st_data = 8'h10,
    st_sum = 8'h20,
    st_crc = 8'h40,
    st_gap = 8'h80
  } state_e;

  state_e state_q;
  logic hi_q;
  logic [5:0] len_q;
  logic [5:0] idx_q;
  logic [7:0] mode_q;
  logic [15:0] frame_checksum_field_q;
  logic [7:0] crc_q;
  logic [7:0] crc_next;
  logic [7:0] cur_byte;
  logic cur_valid;
  logic [31:0] gap_q;
  logic tx_busy;
  logic tx_line;
  logic sent;
  logic gap_end;

  byte_link_if link ();

  // ****************************************
  // Field helpers
  // ****************************************
  // Two-byte fields all leave high byte first, so one helper picks the half
  function automatic logic [7:0] pick_half(input logic [15:0] word, input logic high);
    pick_half = high ? word[15:8] : word[7:0];
  endfunction

  // States that carry a two-byte field flip the half select after each byte
  function automatic logic is_pair(input state_e s);
    is_pair = (s == st_sync) || (s == st_count) || (s == st_sum);
  endfunction

  // ****************************************
  // Byte currently offered to the transmitter
  // ****************************************
  // Multi-byte fields go most significant byte first
  always_comb begin
    cur_byte = 8'h00;
    cur_valid = 1'b0;
    unique case (state_q)
      st_idle: cur_valid = 1'b0;
      st_sync: begin
        cur_byte = pick_half(sync_word, hi_q);
        cur_valid = 1'b1;
      end
      st_count: begin
        cur_byte = pick_half(message_counter_q, hi_q);
        cur_valid = 1'b1;
      end
      st_mode: begin
        cur_byte = mode_q;
        cur_valid = 1'b1;
      end
      st_data: begin
        cur_byte = data_byte;
        cur_valid = data_valid;
      end
      st_sum: begin
        cur_byte = pick_half(frame_checksum_field_q, hi_q);
        cur_valid = 1'b1;
      end
      st_crc: begin
        cur_byte = crc_q;
        cur_valid = 1'b1;
      end
      st_gap: cur_valid = 1'b0;
    endcase
  end

  assign link.valid = cur_valid;
  assign link.data = cur_byte;
  assign sent = cur_valid & link.ready;

  // Gap is over once the line has stayed idle for the full count after the CRC
  assign gap_end = (state_q == st_gap) & ~tx_busy & (gap_q == 32'(gap_len - 1));

  serial_tx #(
    .bit_len(bit_len)
  ) u_tx (
    .clock(clock),
    .rst_b(rst_b),
    .link(link),
    .line_q(tx_line),
    .busy_q(tx_busy)
  );

  // CRC covers every byte before the CRC itself
  crc8_step u_crc (
    .poly(crc_poly),
    .crc_in(crc_q),
    .data_in(cur_byte),
    .crc_out(crc_next)
  );

  // ****************************************
  // Frame sequencer
  // ****************************************
  // A two-byte field moves on only after its low byte has been taken
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= st_idle;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (frame_start) begin
            state_q <= st_sync;
          end
        end
        st_sync: begin
          if (sent && !hi_q) begin
            state_q <= st_count;
          end
        end
        st_count: begin
          if (sent && !hi_q) begin
            state_q <= st_mode;
          end
        end
        st_mode: begin
          if (sent) begin
            state_q <= (len_q == 6'h00) ? st_sum : st_data;
          end
        end
        st_data: begin
          if (sent && (idx_q + 6'h01 == len_q)) begin
            state_q <= st_sum;
          end
        end
        st_sum: begin
          if (sent && !hi_q) begin
            state_q <= st_crc;
          end
        end
        st_crc: begin
          if (sent) begin
            state_q <= st_gap;
          end
        end
        st_gap: begin
          if (gap_end) begin
            state_q <= st_idle;
          end
        end
      endcase
    end
  end

  // High half first; toggling twice leaves it set for the next field
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hi_q <= 1'b1;
    end else if (state_q == st_idle) begin
      hi_q <= 1'b1;
    end else if (sent && is_pair(state_q)) begin
      hi_q <= ~hi_q;
    end
  end

  // Counts data bytes taken; cleared outside the data section
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 6'h00;
    end else if (state_q != st_data) begin
      idx_q <= 6'h00;
    end else if (sent) begin
      idx_q <= idx_q + 6'h01;
    end
  end

  // Mode and length are captured with the start request and held for the frame
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 8'h00;
      len_q <= 6'h00;
    end else if (state_q == st_idle && frame_start) begin
      mode_q <= software_mode;
      len_q <= (data_length > 6'(max_bytes)) ? 6'(max_bytes) : data_length;
    end
  end

  // Gap timer starts only once the last stop bit has left the line
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 32'h00000000;
    end else if (state_q != st_gap || tx_busy) begin
      gap_q <= 32'h00000000;
    end else if (!gap_end) begin
      gap_q <= gap_q + 32'h00000001;
    end
  end

  // ****************************************
  // Checksum and CRC accumulation
  // ****************************************
  // Checksum sees only data bytes; a 16-bit sum of 32 bytes cannot overflow
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_checksum_field_q <= checksum_reset;
    end else if (state_q == st_idle) begin
      frame_checksum_field_q <= checksum_reset;
    end else if (sent && state_q == st_data) begin
      frame_checksum_field_q <= frame_checksum_field_q + {8'h00, data_byte};
    end
  end

  // CRC runs over every byte before itself, sync through checksum
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      crc_q <= crc_init;
    end else if (state_q == st_idle) begin
      crc_q <= crc_init;
    end else if (sent && state_q != st_crc) begin
      crc_q <= crc_next;
    end
  end

  // ****************************************
  // Message counter
  // ****************************************
  // Advances as the frame's CRC is taken at its start bit, so each frame shows a fresh value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      message_counter_q <= counter_reset;
    end else if (state_q == st_crc && sent) begin
      message_counter_q <= message_counter_q + 16'h0001;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Hints are one cycle late; the byte take itself is combinational on data_valid
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      data_ready_q <= 1'b0;
      start_ready_q <= 1'b0;
      frame_done_q <= 1'b0;
    end else begin
      data_ready_q <= (state_q == st_data) & link.ready & ~sent;
      start_ready_q <= (state_q == st_idle) & ~frame_start;
      frame_done_q <= gap_end;
    end
  end

  // Line gets its own flop so the pin never shows a combinational glitch
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_line_q <= 1'b1;
    end else begin
      tx_line_q <= tx_line;
    end
  end
endmodule

// ==== sim/framer_asserts.sv ====
// Concurrent checks on the framer pins
`timescale 1ns/1ps
module framer_asserts
  import framer_pkg::*;
#(
  parameter int unsigned gap_len = gap_cycles,
  parameter int unsigned bit_len = bit_cycles
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic frame_start,
  input wire logic start_ready_q,
  input wire logic frame_done_q,
  input wire logic [15:0] message_counter_q,
  input wire logic tx_line_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ****************
  // Line run lengths
  // ****************
  logic [31:0] hi_q;
  logic [31:0] lo_q;
  // High run starts large so the first frame after reset is no gap fault
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hi_q <= 32'h00ff0000;
      lo_q <= 32'h0;
    end else begin
      hi_q <= tx_line_q ? hi_q + 32'h1 : 32'h0;
      lo_q <= tx_line_q ? 32'h0 : lo_q + 32'h1;
    end
  end
  property p_idle; start_ready_q |-> tx_line_q; endproperty
  a_idle: assert property (p_idle) else $error("line low while idle");
  property p_start; frame_start && start_ready_q |-> ##3 !tx_line_q; endproperty
  a_start: assert property (p_start) else $error("no start bit after request");
  property p_drop; frame_start && start_ready_q |=> !start_ready_q; endproperty
  a_drop: assert property (p_drop) else $error("still idle after request");
  property p_done; frame_done_q |=> !frame_done_q; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  property p_done_gap; frame_done_q |-> tx_line_q && hi_q >= gap_len; endproperty
  a_done_gap: assert property (p_done_gap) else $error("done before gap ran out");
  property p_count; $changed(message_counter_q) |-> message_counter_q == $past(message_counter_q) + 16'h1; endproperty
  a_count: assert property (p_count) else $error("counter step not one");
  // In-frame high runs reach nine bits plus one cycle at most; longer runs are gaps
  property p_gap; $fell(tx_line_q) && hi_q > 10 * bit_len |-> hi_q >= gap_len; endproperty
  a_gap: assert property (p_gap) else $error("gap between frames too short");
  property p_bits; $rose(tx_line_q) |-> lo_q % bit_len == 0; endproperty
  a_bits: assert property (p_bits) else $error("low run not whole bits");
  c_done: cover property (frame_done_q);
  c_count: cover property ($changed(message_counter_q));
  c_start: cover property (frame_start && start_ready_q);
endmodule
bind telemetry_downlink_framer framer_asserts #(.gap_len(gap_len), .bit_len(bit_len)) framer_asserts_inst (
  .clock, .rst_b, .frame_start, .start_ready_q, .frame_done_q, .message_counter_q, .tx_line_q);

// ==== sim/serial_rx_model.sv ====
// Telemetry receiver model on the serial line
`timescale 1ns/1ps
module serial_rx_model #(
  parameter int bl = 8
) (
  input wire logic clock,
  input wire logic line,
  output logic [8:0] char_q,
  output logic got_q
);
  // Samples mid-bit; stop bit lands in char_q[8] so framing faults show
  initial begin
    got_q = 1'b0;
    char_q = 9'h000;
    forever begin
      @(posedge clock);
      #1;
      if (!line) begin
        repeat (bl / 2) @(posedge clock);
        for (int i = 0; i < 9; i++) begin
          repeat (bl) @(posedge clock);
          #1 char_q[i] = line;
        end
        got_q = 1'b1;
        @(posedge clock);
        #1 got_q = 1'b0;
      end
    end
  end
endmodule

// ==== sim/tb_telemetry_downlink_framer.sv ====
// Self-checking bench for the telemetry framer
`timescale 1ns/1ps
module tb_telemetry_downlink_framer;
  import framer_pkg::*;
  localparam int unsigned bl = 8;
  localparam int cc = 10 * bl;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic frame_start = 1'b0;
  logic [7:0] software_mode = 8'h00;
  logic [5:0] data_length = 6'h00;
  logic data_valid = 1'b0;
  logic [7:0] data_byte = 8'h00;
  logic data_ready_q, start_ready_q, frame_done_q, tx_line_q, got_q;
  logic [15:0] message_counter_q;
  logic [8:0] char_q;
  logic [8:0] exp_q[$];
  logic [7:0] crc_acc;
  int err_count = 0;
  int n_compared = 0;
  int n_rx = 0;
  telemetry_downlink_framer #(.gap_len(120), .bit_len(bl)) telemetry_downlink_framer_inst (.clock(clock),
    .rst_b(rst_b), .frame_start(frame_start), .software_mode(software_mode), .data_length(data_length),
    .data_valid(data_valid), .data_byte(data_byte), .data_ready_q(data_ready_q), .start_ready_q(start_ready_q),
    .frame_done_q(frame_done_q), .message_counter_q(message_counter_q), .tx_line_q(tx_line_q));
  serial_rx_model #(.bl(bl)) serial_rx_model_inst (.clock(clock), .line(tx_line_q), .char_q(char_q), .got_q(got_q));
  initial forever #25 clock = ~clock;
  // ****************
  // Checking helpers
  // ****************
  task automatic cmp_char(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: char %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_count(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // MSB-first CRC, no reflection, kept apart from the design's step
  task automatic add(input logic [7:0] b);
    exp_q.push_back({1'b1, b});
    crc_acc = crc_acc ^ b;
    for (int i = 0; i < 8; i++) crc_acc = crc_acc[7] ? ((crc_acc << 1) ^ crc_poly_default) : (crc_acc << 1);
  endtask
  // Each received character is matched with the oldest expectation
  always @(posedge got_q) begin
    n_rx++;
    cmp_char(char_q, exp_q.size() > 0 ? exp_q.pop_front() : ~char_q);
  end
  // Data byte k is put up once the receiver holds byte k-1 and held until byte k is received
  task automatic run_frame(input logic [5:0] len, input logic [15:0] cnt);
    int n;
    int lim;
    logic [15:0] sum;
    logic [7:0] d[32];
    int base;
    lim = (len > 32) ? 32 : int'(len);
    sum = 16'h0;
    crc_acc = 8'h00;
    software_mode = 8'($urandom);
    add(sync_default[15:8]);
    add(sync_default[7:0]);
    add(cnt[15:8]);
    add(cnt[7:0]);
    add(software_mode);
    for (int k = 0; k < lim; k++) begin
      d[k] = 8'($urandom);
      sum = sum + {8'h00, d[k]};
      add(d[k]);
    end
    add(sum[15:8]);
    add(sum[7:0]);
    exp_q.push_back({1'b1, crc_acc});
    n = 0;
    while (start_ready_q !== 1'b1 && n < 200) begin
      @(posedge clock);
      #2 n++;
    end
    if (n >= 200) begin
      err_count++;
      wrap_up();
    end
    cmp_count(message_counter_q, cnt);
    base = n_rx;
    data_length = len;
    if (lim > 0) data_byte = d[0];
    frame_start = 1'b1;
    @(posedge clock);
    #2 frame_start = 1'b0;
    // Byte k goes up once the receiver holds byte k-1, so it was surely taken
    for (int k = 1; k < lim; k++) begin
      n = 0;
      while (n_rx < base + 5 + k && n < 8 * cc) begin
        @(posedge clock);
        #2 n++;
      end
      if (n >= 8 * cc) err_count++;
      data_byte = d[k];
      frame_start = (k == 1);
      if (k == 2) begin
        data_valid = 1'b0;
        n = 0;
        while (data_ready_q !== 1'b1 && n < cc) begin
          @(posedge clock);
          #2 n++;
        end
        cmp_flag(data_ready_q, 1'b1);
        data_valid = 1'b1;
      end
    end
    n = 0;
    while (frame_done_q !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #2 frame_start = 1'b0;
      n++;
    end
    if (n >= 5000) begin
      err_count++;
      wrap_up();
    end
  endtask
  initial begin
    void'($urandom(32'h78bf2534));
    repeat (5) @(posedge clock);
    #2 rst_b = 1'b1;
    data_valid = 1'b1;
    run_frame(6'd0, 16'h0000);
    run_frame(6'd32, 16'h0001);
    run_frame(6'd45, 16'h0002);
    run_frame(6'(1 + $urandom % 5), 16'h0003);
    repeat (200) @(posedge clock);
    cmp_count(16'(exp_q.size()), 16'h0000);
    wrap_up();
  end
endmodule
